// *** design/rsmd_pkg.sv ***
package rsmd_pkg;
   // ---------------------------------------------------------------
   // control bit positions
   // ---------------------------------------------------------------
   localparam int MCTL_RTS_POS     = 1;
   localparam int XFC_NINE_BIT_POS = 0;
   localparam int XFC_AUTO_DIR_POS = 4;
   localparam int XFC_RTS_INV_POS  = 5;
   localparam int ENH_SPECIAL_POS  = 5;
   localparam int IEN_LINE_POS     = 2;
   localparam int STAT_PERR_POS    = 2;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic RTS_IDLE_LEVEL = 1'h1;
   localparam logic RX_EN_RESET    = 1'h0;
   // ---------------------------------------------------------------
   // receive filter decision
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {RSMD_DROP, RSMD_STORE, RSMD_STORE_ADDR} rsmd_act_e;
endpackage : rsmd_pkg

// *** design/rsmd_rx_filter.sv ***
module rsmd_rx_filter
   import rsmd_pkg::*;
(
   input  wire logic       nine_bit_in,   // multidrop mode on
   input  wire logic       special_in,    // auto address match on
   input  wire logic       rx_en_in,      // receiver enabled now
   input  wire logic       parity_in,     // received ninth bit
   input  wire logic [7:0] char_in,       // received character
   input  wire logic [7:0] match_in,      // address match character
   output rsmd_act_e       act_out,       // what to do with the character
   output logic            rx_en_nxt_out  // receiver enable afterwards
);
   always_comb begin
      act_out       = rx_en_in ? RSMD_STORE : RSMD_DROP;
      rx_en_nxt_out = rx_en_in;
      if (!nine_bit_in) begin
         act_out = RSMD_STORE;
      end else if (parity_in) begin
         if (!special_in) begin
            act_out = RSMD_STORE_ADDR;
         end else if (char_in == match_in) begin
            act_out       = RSMD_STORE_ADDR;
            rx_en_nxt_out = 1'h1;
         end else begin
            act_out       = RSMD_DROP;
            rx_en_nxt_out = 1'h0;
         end
      end else if (special_in && !rx_en_in) begin
         act_out = RSMD_DROP;
      end
   end
endmodule // rsmd_rx_filter

// *** design/rsmd_ctrl.sv ***
module rsmd_ctrl
   import rsmd_pkg::*;
(
   input  wire logic       mclk_in,        // 100 MHz clock
   input  wire logic       resetn_in,      // async reset, active low
   input  wire logic       ce_in,          // clock enable
   input  wire logic [7:0] modem_control_reg_in,         // modem control
   input  wire logic [7:0] extra_feature_control_reg_in, // extra feature control
   input  wire logic [7:0] enhanced_feature_reg_in,      // enhanced feature
   input  wire logic [7:0] interrupt_enable_reg_in,      // interrupt enable
   input  wire logic [7:0] address_match_char_in,        // address match char
   input  wire logic       hw_flow_en_in,  // hardware flow control on
   input  wire logic       flow_rts_in,    // rts level from flow control
   input  wire logic       tx_fifo_wr_in,  // host wrote transmit fifo
   input  wire logic       tx_fifo_empty_in,  // transmit fifo empty
   input  wire logic       tx_shift_empty_in, // shift register empty after stop
   input  wire logic       rx_valid_in,    // character received, one pulse
   input  wire logic [7:0] rx_char_in,     // received character
   input  wire logic       rx_parity_in,   // received ninth bit
   input  wire logic       rx_perr_in,     // normal parity error
   input  wire logic       rx_en_set_in,   // controller enables receiver
   input  wire logic       rx_en_clr_in,   // controller disables receiver
   output logic            rts_n_out,      // rts pin
   output logic            rx_en_out,      // receiver enable state
   output logic            rxf_wr_out,     // push into receive fifo
   output logic [7:0]      rxf_data_out,   // data for receive fifo
   output logic            rxf_perr_out,   // parity error position bit
   output logic            line_irq_out    // line status interrupt pulse
);
   // ---------------------------------------------------------------
   // direction control
   // ---------------------------------------------------------------
   logic auto_dir;
   logic invert;
   logic pending_r;
   logic pending_nxt;
   logic tx_done;

   assign auto_dir = extra_feature_control_reg_in[XFC_AUTO_DIR_POS];
   assign invert   = extra_feature_control_reg_in[XFC_RTS_INV_POS];
   assign tx_done  = tx_fifo_empty_in && tx_shift_empty_in;

   // a write in the same cycle as done keeps the line driven
   always_comb begin
      pending_nxt = pending_r;
      if (tx_fifo_wr_in) begin
         pending_nxt = 1'h1;
      end else if (tx_done) begin
         pending_nxt = 1'h0;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pending_r <= 1'h0;
      end else if (ce_in) begin
         pending_r <= pending_nxt;
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rts_n_out <= RTS_IDLE_LEVEL;
      end else if (ce_in) begin
         // next-state view lets the driver turn on in the same edge as the write
         if (auto_dir) begin
            rts_n_out <= invert ? pending_nxt : !pending_nxt;
         end else if (hw_flow_en_in) begin
            rts_n_out <= flow_rts_in;
         end else begin
            rts_n_out <= !modem_control_reg_in[MCTL_RTS_POS];
         end
      end
   end

   // ---------------------------------------------------------------
   // multidrop receive filter
   // ---------------------------------------------------------------
   rsmd_act_e act;
   logic      rx_en_filt;
   logic      nine_bit;
   logic      special;

   assign nine_bit = extra_feature_control_reg_in[XFC_NINE_BIT_POS];
   assign special  = enhanced_feature_reg_in[ENH_SPECIAL_POS];

   // one place decides whether a stored character carries the error flag
   function automatic logic perr_flag(input rsmd_act_e act_i, input logic perr_i);
      return (act_i == RSMD_STORE_ADDR) || perr_i;
   endfunction

   rsmd_rx_filter u_filt (
      .nine_bit_in   (nine_bit),
      .special_in    (special),
      .rx_en_in      (rx_en_out),
      .parity_in     (rx_parity_in),
      .char_in       (rx_char_in),
      .match_in      (address_match_char_in),
      .act_out       (act),
      .rx_en_nxt_out (rx_en_filt)
   );

   // hardware decisions on a received character win over the controller
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_en_out <= RX_EN_RESET;
      end else if (ce_in) begin
         if (rx_valid_in && nine_bit) begin
            rx_en_out <= rx_en_filt;
         end else if (rx_en_set_in) begin
            rx_en_out <= 1'h1;
         end else if (rx_en_clr_in) begin
            rx_en_out <= 1'h0;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rxf_wr_out   <= 1'h0;
         rxf_data_out <= 8'h00;
         rxf_perr_out <= 1'h0;
         line_irq_out <= 1'h0;
      end else if (ce_in) begin
         rxf_wr_out   <= rx_valid_in && (act != RSMD_DROP);
         rxf_data_out <= rx_char_in;
         rxf_perr_out <= perr_flag(act, rx_perr_in);
         // dropped characters never interrupt, even with a line error on them
         line_irq_out <= rx_valid_in && interrupt_enable_reg_in[IEN_LINE_POS]
                         && (act != RSMD_DROP) && perr_flag(act, rx_perr_in);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_write;
      ce_in && tx_fifo_wr_in && auto_dir && !invert;
   endsequence

   a_rts_assert: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_write |=> (rts_n_out == 1'h0)) else $error("rts not driven low after write");
   a_rts_invert: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && tx_fifo_wr_in && auto_dir && invert |=> rts_n_out) else $error("inverted rts wrong");
   a_rts_release: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && auto_dir && !invert && tx_done && !tx_fifo_wr_in |=> rts_n_out)
      else $error("rts not released when idle");
   a_rts_manual: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && !auto_dir && !hw_flow_en_in |=> rts_n_out == !$past(modem_control_reg_in[MCTL_RTS_POS]))
      else $error("manual rts wrong");
   a_rts_flow: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && !auto_dir && hw_flow_en_in |=> rts_n_out == $past(flow_rts_in))
      else $error("flow rts wrong");
   a_data_drop: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && rx_valid_in && nine_bit && !rx_parity_in && !rx_en_out |=> !rxf_wr_out)
      else $error("data stored while receiver off");
   a_addr_flag: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && rx_valid_in && nine_bit && rx_parity_in && !special |=> rxf_wr_out && rxf_perr_out)
      else $error("address byte not flagged");
   a_match_enable: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && rx_valid_in && nine_bit && special && rx_parity_in
      && rx_char_in == address_match_char_in |=> rx_en_out && rxf_wr_out)
      else $error("matching address not taken");
   a_mismatch_off: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && rx_valid_in && nine_bit && special && rx_parity_in
      && rx_char_in != address_match_char_in |=> !rx_en_out && !rxf_wr_out)
      else $error("mismatch not dropped");

   // ---------------------------------------------------------------
   // multi-step checks
   // ---------------------------------------------------------------
   // a frame in flight: written earlier, transmitter not yet drained
   sequence s_tx_busy;
      ce_in && auto_dir && !invert && !tx_fifo_wr_in && !tx_done;
   endsequence

   sequence s_addr_char;
      ce_in && rx_valid_in && nine_bit && rx_parity_in;
   endsequence

   sequence s_data_char;
      ce_in && rx_valid_in && nine_bit && !rx_parity_in;
   endsequence

   a_rts_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_write ##1 s_tx_busy |=> !rts_n_out)
      else $error("rts released while frame in flight");
   a_addr_recheck: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_addr_char ##0 (!special && rx_en_out) |=> rx_en_out && rxf_wr_out && rxf_perr_out)
      else $error("repeat address not flagged");
   a_data_keep: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_data_char ##0 rx_en_out |=> rxf_wr_out && (rxf_perr_out == $past(rx_perr_in)))
      else $error("data lost while receiver on");
   a_plain_store: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      ce_in && rx_valid_in && !nine_bit |=> rxf_wr_out && (rxf_data_out == $past(rx_char_in)))
      else $error("plain character not stored");
   // the interrupt follows the enable bit as it stood when the character came in
   a_addr_irq: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_addr_char ##0 (!special || (rx_char_in == address_match_char_in))
      |=> line_irq_out == $past(interrupt_enable_reg_in[IEN_LINE_POS]))
      else $error("address interrupt wrong");
   a_match_keep: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_addr_char ##0 (special && rx_en_out && (rx_char_in == address_match_char_in))
      |=> rx_en_out && rxf_wr_out && rxf_perr_out)
      else $error("repeat match not stored");
   a_addr_off: assert property (@(posedge mclk_in) disable iff (!resetn_in)
      s_addr_char ##0 (!special && !rx_en_out) |=> !rx_en_out && rxf_wr_out)
      else $error("address changed receiver state");
endmodule // rsmd_ctrl

// *** test/rsmd_tx_station.sv ***
// ---------------------------------------------------------------
// transmitter fifo and shift register seen by the direction logic
// ---------------------------------------------------------------
module rsmd_tx_station #(
   parameter int BIT_CYC = 10    // cycles one character spends in the shifter
) (
   input  wire logic mclk_in,        // clock
   input  wire logic resetn_in,      // async reset, active low
   input  wire logic wr_in,          // host pushes a character
   output logic      fifo_empty_out, // fifo holds nothing
   output logic      shift_empty_out // shifter idle after stop bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] cnt_r;
   int         tmr_r;
   wire        load = (tmr_r == 0) && (cnt_r != 7'h00);
   // load and decrement on one edge, so both empties never show a false gap
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_r <= 7'h00;
         tmr_r <= 0;
      end else begin
         tmr_r <= load ? BIT_CYC : (tmr_r > 0 ? tmr_r - 1 : 0);
         cnt_r <= cnt_r + 7'(wr_in) - 7'(load);
      end
   end
   assign fifo_empty_out  = (cnt_r == 7'h00);
   assign shift_empty_out = (tmr_r == 0);
endmodule // rsmd_tx_station

// *** test/rs485_multidrop_control_test.sv ***
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module rs485_multidrop_control_test import rsmd_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk = 1'h0, rstn = 1'h0, ce = 1'h1, hw = 1'h0, frts = 1'h0, wr = 1'h0;
   logic       rv = 1'h0, rp = 1'h0, pe = 1'h0, rs = 1'h0, rc = 1'h0;
   logic [7:0] mctl = 8'h00, xfctl = 8'h00, efeat = 8'h00, ien = 8'h00, amc = 8'h5A, rch = 8'h00;
   wire        fe, se, rts_n, rxen, fwr, fperr, irq;
   wire  [7:0] fdat;
   logic       e_rts = 1'h1, e_en = 1'h0, e_wr = 1'h0, e_pe = 1'h0, e_irq = 1'h0, pend = 1'h0;
   logic [7:0] e_dat = 8'h00;
   int         err_total = 0, n_compared = 0;
   always #5 clk = ~clk;
   rsmd_tx_station #(.BIT_CYC(10)) u_tx (.mclk_in(clk), .resetn_in(rstn), .wr_in(wr),
      .fifo_empty_out(fe), .shift_empty_out(se));
   rsmd_ctrl u_dut (.mclk_in(clk), .resetn_in(rstn), .ce_in(ce), .modem_control_reg_in(mctl),
      .extra_feature_control_reg_in(xfctl), .enhanced_feature_reg_in(efeat),
      .interrupt_enable_reg_in(ien), .address_match_char_in(amc), .hw_flow_en_in(hw),
      .flow_rts_in(frts), .tx_fifo_wr_in(wr), .tx_fifo_empty_in(fe), .tx_shift_empty_in(se),
      .rx_valid_in(rv), .rx_char_in(rch), .rx_parity_in(rp), .rx_perr_in(pe),
      .rx_en_set_in(rs), .rx_en_clr_in(rc), .rts_n_out(rts_n), .rx_en_out(rxen),
      .rxf_wr_out(fwr), .rxf_data_out(fdat), .rxf_perr_out(fperr), .line_irq_out(irq));
   // ---------------------------------------------------------------
   // reference model
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rstn) begin : model
      logic st, hen, hv;
      if (!rstn) begin
         {e_rts, e_en, e_wr, e_pe, e_irq, pend} = 6'h20;
      end else if (ce) begin
         pend  = wr | (pend & !(fe & se));
         e_rts = xfctl[XFC_AUTO_DIR_POS] ? (xfctl[XFC_RTS_INV_POS] ? pend : !pend)
               : (hw ? frts : !mctl[MCTL_RTS_POS]);
         {st, hen, hv} = 3'h0;
         e_pe = pe;
         if (rv) begin
            if (!xfctl[XFC_NINE_BIT_POS]) st = 1'h1;
            else if (!efeat[ENH_SPECIAL_POS]) begin
               st = rp | e_en;
               if (rp) e_pe = 1'h1;
            end else if (rp && rch == amc) {st, e_pe, hen, hv} = 4'hF;
            else if (rp) hen = e_en;
            else st = e_en;
         end
         e_en  = hen ? hv : (rs | (e_en & !rc));
         e_wr  = st;
         if (st) e_dat = rch;
         e_irq = st & ien[IEN_LINE_POS] & e_pe;
      end
   end
   // ---------------------------------------------------------------
   // checks and stimulus
   // ---------------------------------------------------------------
   task automatic step(input bit act);
      bit auto_on;
      @(negedge clk);
      `CHK("rts_n", e_rts, rts_n)
      `CHK("rx_en", e_en, rxen)
      `CHK("rxf_wr", e_wr, fwr)
      if (e_wr) `CHK("rxf_data", e_dat, fdat)
      if (e_wr) `CHK("rxf_perr", e_pe, fperr)
      `CHK("line_irq", e_irq, irq)
      auto_on = xfctl[XFC_AUTO_DIR_POS];
      rv   = act & $urandom_range(1, 0);
      rp   = $urandom_range(1, 0);
      pe   = ($urandom_range(3, 0) == 0);
      case ($urandom_range(2, 0))
         0: rch = amc;
         1: rch = amc ^ 8'h01;
         default: rch = 8'($urandom);
      endcase
      wr   = act & auto_on & ($urandom_range(7, 0) == 0);
      // idle tail drops flow control so the next mode never starts with it on
      hw   = act & !auto_on & $urandom_range(1, 0);
      rs   = act & !rv & ($urandom_range(15, 0) == 0);
      rc   = act & !rv & !rs & ($urandom_range(15, 0) == 0);
      ce   = ($urandom_range(15, 0) != 0);
      frts = $urandom_range(1, 0);
      mctl = 8'($urandom);
      ien  = 8'($urandom);
   endtask
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #200000;
      err_total++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(52));
      repeat (12) @(posedge clk);
      @(negedge clk) rstn = 1;
      // every mix of auto, invert, 9-bit and special detect; idle tail stops new tx writes
      for (int m = 0; m < 16; m++) begin
         xfctl = {2'h0, m[1], m[0], 3'h0, m[2]};
         efeat = {2'h0, m[3], 5'h00};
         repeat (150) step(1'b1);
         repeat (40) step(1'b0);
      end
      tally_and_finish();
   end
endmodule // rs485_multidrop_control_test
